// *** include/htmc_pkg.sv ***
package htmc_pkg;
	// Register pointer values
	localparam logic [7:0]  REG_TEMP     = 8'h00;
	localparam logic [7:0]  REG_HUM      = 8'h01;
	localparam logic [7:0]  REG_CFG      = 8'h02;
	localparam logic [7:0]  REG_UID_HI   = 8'hfb;
	localparam logic [7:0]  REG_UID_MID  = 8'hfc;
	localparam logic [7:0]  REG_UID_LO   = 8'hfd;
	localparam logic [7:0]  REG_MAKER    = 8'hfe;
	localparam logic [7:0]  REG_PART     = 8'hff;
	localparam logic [7:0]  PTR_RESET    = 8'h00;
	// Bus address and reset values
	localparam logic [6:0]  BUS_ADDR     = 7'h40;
	localparam logic [15:0] CFG_RESET    = 16'h1000;
	localparam logic [15:0] CFG_WR_MASK  = 16'h3700;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	// Configuration field positions
	localparam int          CFG_SRST_BIT = 15;
	localparam int          CFG_HEAT_BIT = 13;
	localparam int          CFG_MODE_BIT = 12;
	localparam int          CFG_SUP_BIT  = 11;
	localparam int          CFG_TRES_BIT = 10;
	localparam int          CFG_HRES_LSB = 8;
	// Resolution encodings
	localparam logic [1:0]  HRES_14      = 2'h0;
	localparam logic [1:0]  HRES_11      = 2'h1;
	localparam logic [1:0]  HRES_8       = 2'h2;
	// Clock rate and bit slot counts
	localparam int          SYS_CLK_MHZ  = 20;
	localparam logic [3:0]  SLOT_ACK     = 4'h8;
	localparam logic [3:0]  SLOT_END     = 4'h9;
	// Bus and conversion states
	typedef enum logic [2:0] {B_IDLE, B_ADDR, B_PTR, B_WDATA, B_RDATA, B_IGNORE} htmc_bus_e;
	typedef enum logic [1:0] {C_SLEEP, C_TEMP, C_HUM} htmc_conv_e;
endpackage

// *** core/htmc_core.sv ***
`timescale 1ns/10ps
// Function
// - Combined mode converts temperature first, then humidity, per trigger.
// - Sleeps after reset; no conversion until a trigger.
// - Config bit 12 set selects combined acquisition.
// - Config bit 12 clear: each trigger converts one quantity only.
// - Config bit 10 picks temperature resolution: 0 is 14 bits, 1 is 11.
// - Config bits 9:8 pick humidity resolution: 00 14, 01 11, 10 8 bits.
// - Combined mode: pointer-only write of 0x00 triggers conversion.
// - Single mode: pointer-only 0x00 triggers temperature, 0x01 humidity.
// - Combined result read returns temperature then humidity in one transaction.
// - Reads of not yet refreshed results are NACKed.
// - Configuration persists across measurements.
// - Reading results during a conversion leaves it undisturbed.
// - Writing address 0x00 or 0x01 during conversion aborts it.
// - 8-bit pointer selects register; a write with a valid pointer byte reloads it.
// - Pointer resets to 0x00.
// - Results are 16 bits, code in 15:2, bits 1:0 zero.
// - Addresses 0xFB to 0xFD hold a read-only unique identifier.
// - Answers bus address 1000000 only; other addresses NACKed.
// - Data bytes to read-only registers and unused pointers are NACKed.
// - Registers travel MSB byte first, MSB bit first.
// - Back to sleep after conversion; supply flag refreshed at reset and trigger.
module htmc_core #(
	parameter int          CONV_T14_US = 7000,      // Temperature 14-bit time
	parameter int          CONV_T11_US = 4000,      // Temperature 11-bit time
	parameter int          CONV_H14_US = 7000,      // Humidity 14-bit time
	parameter int          CONV_H11_US = 4000,      // Humidity 11-bit time
	parameter int          CONV_H8_US  = 3000,      // Humidity 8-bit time
	parameter logic [15:0] UID_HI      = 16'h1234,  // Arbitrary identifier
	parameter logic [15:0] UID_MID     = 16'h5678,  // Arbitrary identifier
	parameter logic [15:0] UID_LO      = 16'h9a00,  // Arbitrary identifier
	parameter logic [15:0] MAKER_CODE  = 16'h0a5a,  // Arbitrary value
	parameter logic [15:0] PART_CODE   = 16'h0c3c   // Arbitrary value
) (
	input  wire logic        sys_clk_i,    // System clock
	input  wire logic        reset_i,      // Synchronous reset
	input  wire logic        scl_i,        // Bus clock, link domain
	input  wire logic        sda_i,        // Bus data level
	output logic             sda_o,        // Bus data drive level
	output logic             sda_oe_n_o,   // Low while pulling data
	input  wire logic        supply_low_i, // Supply monitor level
	input  wire logic [13:0] temp_code_i,  // Temperature converter code
	input  wire logic [13:0] humid_code_i, // Humidity converter code
	output logic             busy_o,       // Measurement mode
	output logic             heater_on_o   // Heater active
);
	////////////////////////////////////////////////////////////////
	// Cycle counts from times
	localparam int T14_CYC = CONV_T14_US * htmc_pkg::SYS_CLK_MHZ;
	localparam int T11_CYC = CONV_T11_US * htmc_pkg::SYS_CLK_MHZ;
	localparam int H14_CYC = CONV_H14_US * htmc_pkg::SYS_CLK_MHZ;
	localparam int H11_CYC = CONV_H11_US * htmc_pkg::SYS_CLK_MHZ;
	localparam int H8_CYC  = CONV_H8_US * htmc_pkg::SYS_CLK_MHZ;

	// Refuse times the counter cannot serve
	if (CONV_T14_US < 1 || CONV_T11_US < 1 || CONV_H14_US < 1 || CONV_H11_US < 1 || CONV_H8_US < 1 ||
	    T14_CYC >= 2**24 || H14_CYC >= 2**24 || T11_CYC >= 2**24 || H11_CYC >= 2**24 || H8_CYC >= 2**24) begin : g_chk
		$error("conversion time out of range");
	end

	////////////////////////////////////////////////////////////////
	// Link domain: data bit caught on the bus clock rise
	logic       lnk_bit_ff;
	always_ff @(posedge scl_i) begin
		lnk_bit_ff <= sda_i;
	end

	// Two-stage synchronisers for pins and link bit
	logic [3:0] meta_ff;
	logic [3:0] sync_ff;
	logic [1:0] prev_ff;
	logic       rise_d_ff;
	always_ff @(posedge sys_clk_i) begin
		meta_ff   <= {scl_i, sda_i, lnk_bit_ff, supply_low_i};
		sync_ff   <= meta_ff;
		prev_ff   <= sync_ff[3:2];
		rise_d_ff <= sync_ff[3] & ~prev_ff[1];
	end

	// Bus events
	wire scl_s    = sync_ff[3];
	wire sda_s    = sync_ff[2];
	wire bit_s    = sync_ff[1];
	wire sup_s    = sync_ff[0];
	wire start_ev = scl_s & prev_ff[1] & prev_ff[0] & ~sda_s;
	wire stop_ev  = scl_s & prev_ff[1] & ~prev_ff[0] & sda_s;
	wire fall_ev  = ~scl_s & prev_ff[1];

	////////////////////////////////////////////////////////////////
	// State declarations
	htmc_pkg::htmc_bus_e  bus_ff;
	htmc_pkg::htmc_conv_e conv_ff;
	logic [3:0]  cnt_ff;
	logic [7:0]  sh_ff;
	logic        mack_ff;
	logic        sda_oe_n_ff;
	logic [7:0]  ptr_ff;
	logic [7:0]  rd_ptr_ff;
	logic        rd_lo_ff;
	logic [1:0]  wcnt_ff;
	logic [7:0]  whi_ff;
	logic [15:0] cfg_ff;
	logic        sup_flag_ff;
	logic        sup_pend_ff;
	logic        trig_ff;
	logic        abort_ff;
	logic        comb_ff;
	logic        tval_ff;
	logic        hval_ff;
	logic [23:0] cyc_ff;
	logic [15:0] temp_res_ff;
	logic [15:0] hum_res_ff;
	logic        busy_ff;
	logic        heat_ff;

	// Register read value by pointer
	function automatic logic [15:0] reg_value(input logic [7:0] p, input logic [15:0] t, input logic [15:0] h,
	                                          input logic [15:0] c);
		case (p)
			htmc_pkg::REG_TEMP:    reg_value = t;
			htmc_pkg::REG_HUM:     reg_value = h;
			htmc_pkg::REG_CFG:     reg_value = c;
			htmc_pkg::REG_UID_HI:  reg_value = UID_HI;
			htmc_pkg::REG_UID_MID: reg_value = UID_MID;
			htmc_pkg::REG_UID_LO:  reg_value = UID_LO;
			htmc_pkg::REG_MAKER:   reg_value = MAKER_CODE;
			htmc_pkg::REG_PART:    reg_value = PART_CODE;
			default:               reg_value = 16'h0000;
		endcase
	endfunction

	// Decodes for the bus side
	wire        is_result  = (sh_ff == htmc_pkg::REG_TEMP) | (sh_ff == htmc_pkg::REG_HUM);
	wire        ptr_valid  = is_result | (sh_ff == htmc_pkg::REG_CFG) | (sh_ff >= htmc_pkg::REG_UID_HI);
	wire        addr_hit   = sh_ff[7:1] == htmc_pkg::BUS_ADDR;
	wire        temp_rdy   = tval_ff & (~comb_ff | hval_ff);
	wire        hum_rdy    = hval_ff & (~comb_ff | tval_ff);
	wire        rd_ready   = (ptr_ff == htmc_pkg::REG_TEMP) ? temp_rdy :
	                         (ptr_ff == htmc_pkg::REG_HUM) ? hum_rdy : 1'b1;
	wire [15:0] cfg_rd     = cfg_ff | (16'(sup_flag_ff) << htmc_pkg::CFG_SUP_BIT);
	wire [15:0] rd_word    = reg_value(rd_ptr_ff, temp_res_ff, hum_res_ff, cfg_rd);
	wire [7:0]  tx_byte    = rd_lo_ff ? rd_word[7:0] : rd_word[15:8];
	wire [2:0]  bit_idx    = (cnt_ff == htmc_pkg::SLOT_END) ? 3'h7 : ~cnt_ff[2:0];
	wire        byte_done  = fall_ev & (cnt_ff == htmc_pkg::SLOT_ACK);
	wire        cfg_we     = byte_done & (bus_ff == htmc_pkg::B_WDATA) & (ptr_ff == htmc_pkg::REG_CFG) &
	                         (wcnt_ff == 2'h1);
	wire        ptr_only   = (bus_ff == htmc_pkg::B_WDATA) & (wcnt_ff == 2'h0) &
	                         ((ptr_ff == htmc_pkg::REG_TEMP) | (ptr_ff == htmc_pkg::REG_HUM));
	wire [15:0] cfg_wdata  = {whi_ff, sh_ff};
	wire        srst       = cfg_we & cfg_wdata[htmc_pkg::CFG_SRST_BIT];
	wire        abort_req  = byte_done & (bus_ff == htmc_pkg::B_PTR) & is_result & busy_ff;

	////////////////////////////////////////////////////////////////
	// Bit shifter and slot counter
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || start_ev || stop_ev) begin
			cnt_ff <= 4'h0;
		end else if (rise_d_ff) begin
			cnt_ff <= cnt_ff + 4'h1;
			if (cnt_ff < htmc_pkg::SLOT_ACK) begin
				sh_ff <= {sh_ff[6:0], bit_s};
			end else begin
				mack_ff <= ~bit_s;
			end
		end else if (fall_ev && cnt_ff == htmc_pkg::SLOT_END) begin
			cnt_ff <= 4'h0;
		end
	end

	// Transaction state, acknowledge and transmit drive
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			bus_ff      <= htmc_pkg::B_IDLE;
			sda_oe_n_ff <= 1'b1;
			ptr_ff      <= htmc_pkg::PTR_RESET;
			rd_ptr_ff   <= htmc_pkg::PTR_RESET;
			rd_lo_ff    <= 1'b0;
			wcnt_ff     <= 2'h0;
			whi_ff      <= 8'h00;
		end else if (start_ev || stop_ev) begin
			bus_ff      <= start_ev ? htmc_pkg::B_ADDR : htmc_pkg::B_IDLE;
			sda_oe_n_ff <= 1'b1;
			rd_ptr_ff   <= ptr_ff;
			rd_lo_ff    <= 1'b0;
		end else if (byte_done) begin
			sda_oe_n_ff <= 1'b1;
			case (bus_ff)
				htmc_pkg::B_ADDR: begin
					if (addr_hit && (!sh_ff[0] || rd_ready)) begin
						sda_oe_n_ff <= 1'b0;
						bus_ff      <= sh_ff[0] ? htmc_pkg::B_RDATA : htmc_pkg::B_PTR;
					end else begin
						bus_ff <= htmc_pkg::B_IGNORE;
					end
				end
				htmc_pkg::B_PTR: begin
					wcnt_ff <= 2'h0;
					if (ptr_valid) begin
						sda_oe_n_ff <= 1'b0;
						ptr_ff      <= sh_ff;
						bus_ff      <= htmc_pkg::B_WDATA;
					end else begin
						bus_ff <= htmc_pkg::B_IGNORE;
					end
				end
				htmc_pkg::B_WDATA: begin
					sda_oe_n_ff <= ptr_ff != htmc_pkg::REG_CFG;
					whi_ff      <= sh_ff;
					wcnt_ff     <= (wcnt_ff == 2'h1) ? 2'h0 : 2'h1;
					if (wcnt_ff == 2'h0 && ptr_ff != htmc_pkg::REG_CFG) begin
						wcnt_ff <= 2'h2;
					end
				end
				htmc_pkg::B_RDATA: begin
					rd_lo_ff <= ~rd_lo_ff;
					if (rd_lo_ff && rd_ptr_ff == htmc_pkg::REG_TEMP) begin
						rd_ptr_ff <= htmc_pkg::REG_HUM;
					end
				end
				default: bus_ff <= bus_ff;
			endcase
		end else if (fall_ev) begin
			// Data bit or release; a master NACK ends the read
			sda_oe_n_ff <= 1'b1;
			if (bus_ff == htmc_pkg::B_RDATA) begin
				if (cnt_ff == htmc_pkg::SLOT_END && !mack_ff) begin
					bus_ff <= htmc_pkg::B_IGNORE;
				end else begin
					sda_oe_n_ff <= tx_byte[bit_idx];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Trigger, abort and configuration
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			trig_ff  <= 1'b0;
			abort_ff <= 1'b0;
			cfg_ff   <= htmc_pkg::CFG_RESET;
		end else begin
			trig_ff  <= (start_ev | stop_ev) & ptr_only;
			abort_ff <= abort_req | srst;
			if (srst) begin
				cfg_ff <= htmc_pkg::CFG_RESET;
			end else if (cfg_we) begin
				cfg_ff <= cfg_wdata & htmc_pkg::CFG_WR_MASK;
			end
		end
	end

	// Supply flag caught after reset release and at each trigger
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			sup_pend_ff <= 1'b1;
			sup_flag_ff <= 1'b0;
		end else if (sup_pend_ff || trig_ff) begin
			sup_pend_ff <= 1'b0;
			sup_flag_ff <= sup_s;
		end
	end

	////////////////////////////////////////////////////////////////
	// Conversion lengths by resolution
	wire        tres  = cfg_ff[htmc_pkg::CFG_TRES_BIT];
	wire [1:0]  hres  = cfg_ff[htmc_pkg::CFG_HRES_LSB +: 2];
	wire [23:0] t_len = tres ? 24'(T11_CYC) : 24'(T14_CYC);
	wire [23:0] h_len = (hres == htmc_pkg::HRES_14) ? 24'(H14_CYC) :
	                    (hres == htmc_pkg::HRES_11) ? 24'(H11_CYC) : 24'(H8_CYC);
	wire        t_end = (conv_ff == htmc_pkg::C_TEMP) & (cyc_ff == t_len - 24'h1);
	wire        h_end = (conv_ff == htmc_pkg::C_HUM) & (cyc_ff == h_len - 24'h1);

	// Conversion sequencer
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			conv_ff     <= htmc_pkg::C_SLEEP;
			cyc_ff      <= 24'h0;
			comb_ff     <= 1'b0;
			tval_ff     <= 1'b0;
			hval_ff     <= 1'b0;
			temp_res_ff <= htmc_pkg::RESULT_RESET;
			hum_res_ff  <= htmc_pkg::RESULT_RESET;
		end else if (abort_ff) begin
			conv_ff <= htmc_pkg::C_SLEEP;
		end else if (trig_ff) begin
			cyc_ff  <= 24'h0;
			comb_ff <= cfg_ff[htmc_pkg::CFG_MODE_BIT];
			if (cfg_ff[htmc_pkg::CFG_MODE_BIT] || ptr_ff == htmc_pkg::REG_TEMP) begin
				conv_ff <= htmc_pkg::C_TEMP;
				tval_ff <= 1'b0;
				hval_ff <= hval_ff & ~cfg_ff[htmc_pkg::CFG_MODE_BIT];
			end else begin
				conv_ff <= htmc_pkg::C_HUM;
				hval_ff <= 1'b0;
			end
		end else if (t_end) begin
			temp_res_ff <= {temp_code_i, 2'b00};
			tval_ff     <= 1'b1;
			cyc_ff      <= 24'h0;
			conv_ff     <= comb_ff ? htmc_pkg::C_HUM : htmc_pkg::C_SLEEP;
		end else if (h_end) begin
			hum_res_ff <= {humid_code_i, 2'b00};
			hval_ff    <= 1'b1;
			conv_ff    <= htmc_pkg::C_SLEEP;
		end else if (conv_ff != htmc_pkg::C_SLEEP) begin
			cyc_ff <= cyc_ff + 24'h1;
		end
	end

	// Registered outputs
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			busy_ff <= 1'b0;
			heat_ff <= 1'b0;
		end else begin
			busy_ff <= conv_ff != htmc_pkg::C_SLEEP;
			heat_ff <= (conv_ff != htmc_pkg::C_SLEEP) & cfg_ff[htmc_pkg::CFG_HEAT_BIT];
		end
	end

	assign sda_o       = 1'b0;
	assign sda_oe_n_o  = sda_oe_n_ff;
	assign busy_o      = busy_ff;
	assign heater_on_o = heat_ff;

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	chk_ptr_reset: assert property (disable iff (1'b0) reset_i |=> ptr_ff == 8'h00)
		else $error("pointer not cleared by reset");
	chk_sleep_hold: assert property (conv_ff == htmc_pkg::C_SLEEP && !trig_ff |=> conv_ff == htmc_pkg::C_SLEEP)
		else $error("conversion started without trigger");
	chk_comb_order: assert property (t_end && comb_ff && !abort_ff && !trig_ff |=> conv_ff == htmc_pkg::C_HUM)
		else $error("humidity did not follow temperature");
	chk_bad_addr: assert property (byte_done && bus_ff == htmc_pkg::B_ADDR && !addr_hit |=> sda_oe_n_ff[*2])
		else $error("foreign address acknowledged");
	chk_nack_busy: assert property (byte_done && bus_ff == htmc_pkg::B_ADDR && sh_ff[0] && !rd_ready |=> sda_oe_n_ff)
		else $error("read acknowledged before data ready");
	chk_ro_nack: assert property (byte_done && bus_ff == htmc_pkg::B_WDATA && ptr_ff != htmc_pkg::REG_CFG |=> sda_oe_n_ff)
		else $error("read-only write acknowledged");
	chk_abort_conv: assert property (abort_ff |=> conv_ff == htmc_pkg::C_SLEEP && $stable({tval_ff, hval_ff}))
		else $error("conversion not aborted");
	chk_result_low: assert property (temp_res_ff[1:0] == 2'b00 && hum_res_ff[1:0] == 2'b00)
		else $error("result low bits not zero");
	chk_temp_len: assert property (t_end && !abort_ff && !trig_ff |=> tval_ff && temp_res_ff == {$past(temp_code_i), 2'b00})
		else $error("temperature result not stored at end");
	chk_hum_len: assert property (h_end && !abort_ff && !trig_ff |=> hval_ff ##1 conv_ff == htmc_pkg::C_SLEEP)
		else $error("humidity result not stored at end");
	chk_cfg_keep: assert property (!cfg_we |=> $stable(cfg_ff))
		else $error("configuration changed without write");
	chk_ptr_load: assert property (byte_done && bus_ff == htmc_pkg::B_PTR && ptr_valid |=> ptr_ff == $past(sh_ff))
		else $error("pointer not loaded");
	chk_trig_start: assert property (trig_ff && !abort_ff |=> conv_ff != htmc_pkg::C_SLEEP ##1 busy_o)
		else $error("trigger did not start conversion");

	cov_comb_done: cover property (t_end && comb_ff ##[1:1000] h_end);
	cov_busy_nack: cover property (byte_done && bus_ff == htmc_pkg::B_ADDR && sh_ff[0] && !rd_ready);
	cov_abort: cover property (abort_ff && busy_ff);
endmodule // htmc_core

// *** dv/htmc_host_model.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Bus master: open drain, clock stands high between frames
module htmc_host_model #(
	parameter int QTR_NS = 625      // Quarter bus clock period, 400 kHz
) (
	input  wire logic sda_i,        // Resolved data line
	output logic      scl_o,        // Bus clock
	output logic      pull_o        // High while pulling data low
);
	// Idle bus: both lines released
	initial begin
		scl_o = 1'h1;
		pull_o = 1'h0;
	end
	// One bit: data changes while clock is low, sampled mid high phase
	task automatic bit_io(input logic b, output logic r);
		pull_o = ~b;
		#(QTR_NS) scl_o = 1'h1;
		#(QTR_NS) r = sda_i;
		#(QTR_NS) scl_o = 1'h0;
		#(QTR_NS);
	endtask
	// Start or repeated start: data falls while clock is high
	task automatic start_cond();
		pull_o = 1'h0;
		#(QTR_NS) scl_o = 1'h1;
		#(QTR_NS) pull_o = 1'h1;
		#(QTR_NS) scl_o = 1'h0;
		#(QTR_NS);
	endtask
	// Stop: data rises while clock is high, then the bus rests
	task automatic stop_cond();
		pull_o = 1'h1;
		#(QTR_NS) scl_o = 1'h1;
		#(QTR_NS) pull_o = 1'h0;
		#(2 * QTR_NS);
	endtask
	// Byte out and in, then the acknowledge bit; send ff to read
	task automatic byte_io(input logic [7:0] b, input logic ack_n, output logic [7:0] r, output logic nack);
		for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
		bit_io(ack_n, nack);
	endtask
endmodule // htmc_host_model

// *** dv/htmc_core_bench.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module htmc_core_bench;
	logic        sys_clk_i;
	logic        reset_i;
	logic        supply_low_i;
	logic [13:0] temp_code_i;
	logic [13:0] humid_code_i;
	logic        sda_o;
	logic        sda_oe_n_o;
	logic        busy_o;
	logic        heater_on_o;
	logic        scl;
	logic        pull;
	wire         sda_line;
	int          checked;
	int          num_errors;
	// Identifier values: the core's arbitrary defaults
	logic [15:0] id_exp [5] = '{16'h1234, 16'h5678, 16'h9a00, 16'h0a5a, 16'h0c3c};

	// Open drain line with pull-up
	assign sda_line = ~pull & (sda_oe_n_o | sda_o);

	htmc_core #(.CONV_T14_US(60), .CONV_T11_US(15), .CONV_H14_US(20), .CONV_H11_US(15), .CONV_H8_US(10)) uut (
		.sys_clk_i    (sys_clk_i),
		.reset_i      (reset_i),
		.scl_i        (scl),
		.sda_i        (sda_line),
		.sda_o        (sda_o),
		.sda_oe_n_o   (sda_oe_n_o),
		.supply_low_i (supply_low_i),
		.temp_code_i  (temp_code_i),
		.humid_code_i (humid_code_i),
		.busy_o       (busy_o),
		.heater_on_o  (heater_on_o)
	);

	htmc_host_model m (
		.sda_i  (sda_line),
		.scl_o  (scl),
		.pull_o (pull)
	);

	// System clock, 50 ns
	initial begin
		sys_clk_i = 1'h0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Comparisons and the verdict
	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("Counts: %0d checked, %0d errors", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Write transaction: address, pointer, then nd data bytes; nk holds the four acknowledge bits
	task automatic bus_write(input logic [6:0] adr, input logic [7:0] ptr, input logic [15:0] d, input int nd,
		output logic [3:0] nk);
		logic [7:0] r;
		nk = 4'h0;
		m.start_cond();
		m.byte_io({adr, 1'h0}, 1'h1, r, nk[3]);
		m.byte_io(ptr, 1'h1, r, nk[2]);
		if (nd > 0) m.byte_io(d[15:8], 1'h1, r, nk[1]);
		if (nd > 1) m.byte_io(d[7:0], 1'h1, r, nk[0]);
		m.stop_cond();
	endtask
	// Read transaction of nb bytes at the current pointer; last byte is refused by the master
	task automatic bus_read(input int nb, output logic nk, output logic [31:0] d);
		logic [7:0] r;
		logic       x;
		d = 32'h0;
		m.start_cond();
		m.byte_io({htmc_pkg::BUS_ADDR, 1'h1}, 1'h1, r, nk);
		if (nk === 1'h0) for (int i = 0; i < nb; i++) begin
			m.byte_io(8'hff, (i == nb - 1), r, x);
			d = {d[23:0], r};
		end
		m.stop_cond();
	endtask
	// Bounded wait for the conversion to finish
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy_o !== 1'h0 && n < 4000) begin
			@(posedge sys_clk_i);
			n++;
		end
	endtask

	// Watchdog, well beyond the expected 3 ms of traffic
	initial begin
		#4ms;
		num_errors++;
		conclude();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic        nk;
		logic [3:0]  nk4;
		logic [31:0] d;
		logic [15:0] cfg;
		checked = 0;
		num_errors = 0;
		reset_i = 1'h1;
		supply_low_i = 1'h1;
		temp_code_i = 14'h2abc;
		humid_code_i = 14'h1357;
		repeat (8) @(posedge sys_clk_i);
		#2 reset_i = 1'h0;
		repeat (6) @(posedge sys_clk_i);
		cmp_bit(busy_o, 1'h0);
		bus_read(2, nk, d);
		cmp_bit(nk, 1'h1);
		bus_write(7'h41, 8'h02, 16'h0000, 0, nk4);
		cmp_bit(nk4[3], 1'h1);
		bus_write(htmc_pkg::BUS_ADDR, 8'h05, 16'h0000, 0, nk4);
		cmp_bit(nk4[2], 1'h1);
		bus_write(htmc_pkg::BUS_ADDR, 8'hfe, 16'h0000, 2, nk4);
		cmp_word({12'h0, nk4}, 16'h0003);
		// Identifier registers, each reached by its own pointer write
		for (int i = 0; i < 5; i++) begin
			bus_write(htmc_pkg::BUS_ADDR, 8'hfb + 8'(i), 16'h0000, 0, nk4);
			bus_read(2, nk, d);
			cmp_word(d[15:0], id_exp[i]);
		end
		bus_write(htmc_pkg::BUS_ADDR, 8'h02, 16'h0000, 0, nk4);
		bus_read(2, nk, d);
		cmp_word(d[15:0], htmc_pkg::CFG_RESET | 16'h0800);
		// Combined: 11-bit temperature, 14-bit humidity
		@(posedge sys_clk_i);
		#2 supply_low_i = 1'h0;
		bus_write(htmc_pkg::BUS_ADDR, 8'h02, 16'h1400, 2, nk4);
		bus_write(htmc_pkg::BUS_ADDR, 8'h00, 16'h0000, 0, nk4);
		cmp_bit(busy_o, 1'h1);
		cmp_bit(heater_on_o, 1'h0);
		bus_read(4, nk, d);
		cmp_bit(nk, 1'h1);
		wait_idle();
		cmp_bit(busy_o, 1'h0);
		bus_read(4, nk, d);
		cmp_word(d[31:16], {14'h2abc, 2'h0});
		cmp_word(d[15:0], {14'h1357, 2'h0});
		bus_write(htmc_pkg::BUS_ADDR, 8'h02, 16'h0000, 0, nk4);
		bus_read(2, nk, d);
		cmp_word(d[15:0], 16'h1400);
		// Single mode with heater, every resolution code in turn
		for (int k = 0; k < 3; k++) begin
			@(posedge sys_clk_i);
			#2 humid_code_i = 14'h0aa0 + 14'(k);
			temp_code_i = 14'h3f00 + 14'(k);
			cfg = 16'h2000 | 16'(k << 8) | 16'((k & 1) << 10);
			bus_write(htmc_pkg::BUS_ADDR, 8'h02, cfg, 2, nk4);
			bus_write(htmc_pkg::BUS_ADDR, 8'h01, 16'h0000, 0, nk4);
			cmp_bit(heater_on_o, 1'h1);
			wait_idle();
			bus_read(2, nk, d);
			cmp_word(d[15:0], {14'h0aa0 + 14'(k), 2'h0});
			bus_write(htmc_pkg::BUS_ADDR, 8'h00, 16'h0000, 0, nk4);
			cmp_bit(busy_o, 1'h1);
			wait_idle();
			bus_read(2, nk, d);
			cmp_word(d[15:0], {14'h3f00 + 14'(k), 2'h0});
		end
		// A write to a result address mid-conversion aborts it; a data byte suppresses the retrigger
		bus_write(htmc_pkg::BUS_ADDR, 8'h00, 16'h0000, 0, nk4);
		cmp_bit(busy_o, 1'h1);
		bus_write(htmc_pkg::BUS_ADDR, 8'h00, 16'h0000, 1, nk4);
		cmp_bit(busy_o, 1'h0);
		cmp_bit(nk4[1], 1'h1);
		bus_read(2, nk, d);
		cmp_bit(nk, 1'h1);
		// Soft reset bit restores the configuration value
		bus_write(htmc_pkg::BUS_ADDR, 8'h02, 16'h8000, 2, nk4);
		bus_read(2, nk, d);
		cmp_word(d[15:0], htmc_pkg::CFG_RESET);
		conclude();
	end
endmodule // htmc_core_bench
